// *** rtl/lpm_map.svh ***
`ifndef LPM_MAP_SVH
`define LPM_MAP_SVH
`define LPM_OFF_PROT 12'h000
`define LPM_OFF_SBY 12'h004
`define LPM_OFF_MSTP 12'h008
`define LPM_OFF_DPS 12'h00c
`define LPM_OFF_LVD 12'h010
`define LPM_OFF_CGC 12'h014
`define LPM_OFF_STAT 12'h018
`define LPM_PROT_KEY 8'ha5
`define LPM_PROT_MASK 8'h0b
`define LPM_BIT_CLK_WE 0
`define LPM_BIT_MODE_WE 1
`define LPM_BIT_VMON_WE 3
`define LPM_BIT_SBSEL 15
`define LPM_BIT_BUS_OE 14
`define LPM_BIT_ACS_EN 31
`define LPM_BIT_POD_IE 16
`define LPM_BIT_BCLK 30
`define LPM_BIT_DPSE 7
`define LPM_DCUT_FULL 2'b11
`define LPM_BIT_M1RI 0
`define LPM_BIT_M2RI 1
`define LPM_MOD_TMR 0
`define LPM_MOD_POD 1
`define LPM_RST_PROT 8'h00
`define LPM_RST_SBSEL 1'b0
`define LPM_RST_BUS_OE 1'b1
`define LPM_RST_CGC 8'h00
`endif

// *** rtl/lpm_pkg.sv ***
package lpm_pkg;

   typedef enum logic [4:0] {
      LPM_RUN = 5'b00001,
      LPM_SLEEP = 5'b00010,
      LPM_ACS = 5'b00100,
      LPM_SSTBY = 5'b01000,
      LPM_DSTBY = 5'b10000
   } lpm_mode_e;

   // Peripheral bits: timer, alarm, periodic, watchdog, usb, mon1, mon2,
   // oscillator stop.
   typedef struct packed {
      logic nmi;
      logic [15:0] irq;
      logic [7:0] periph;
   } lpm_wake_s;

   typedef struct packed {
      logic bclk_keep;
      logic tmr_pins_keep;
      logic rtc_pins_keep;
      logic bus_hold;
      logic bus_hiz;
   } lpm_pin_s;

endpackage

// *** rtl/lpm_wake.sv ***
`timescale 1ns/1ps
`include "lpm_map.svh"
module lpm_wake
   import lpm_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input lpm_wake_s src,
   input lpm_mode_e mode,
   input wire logic pod_event,
   input wire logic pod_irq_en,
   output logic wake_req,
   output logic pod_irq_q,
   output logic pod_pend_q
);
   logic any_src;
   logic pod_hit;

   assign any_src = src.nmi | (|src.irq) | (|src.periph);
   assign pod_hit = pod_event & pod_irq_en;

   always_comb begin
      case (mode)
         LPM_SLEEP: wake_req = any_src | pod_hit;
         LPM_ACS, LPM_SSTBY, LPM_DSTBY: wake_req = any_src;
         default: wake_req = 1'b0;
      endcase
   end

   // The event is latched in clock stop and only delivered after return.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pod_pend_q <= 1'b0;
      end else if (mode == LPM_ACS && pod_hit) begin
         pod_pend_q <= 1'b1;
      end else if (mode == LPM_RUN) begin
         pod_pend_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pod_irq_q <= 1'b0;
      end else begin
         pod_irq_q <= (mode == LPM_RUN) && (pod_hit || pod_pend_q);
      end
   end

   a_pod_latch_nowake: assert property (@(posedge clk)
      disable iff (!rst_n)
      mode == LPM_ACS && pod_hit && !any_src |-> !wake_req ##1 pod_pend_q)
      else $error("port disable event in clock stop not latched or woke");
   a_pod_late_irq: assert property (@(posedge clk)
      disable iff (!rst_n)
      pod_pend_q && mode == LPM_RUN |=> pod_irq_q && !pod_pend_q)
      else $error("pending port disable interrupt not raised after wake");

endmodule // lpm_wake

// *** rtl/lpm_top.sv ***
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "lpm_map.svh"
module lpm_top
   import lpm_pkg::*;
#(
   parameter int NMOD = 3
)(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic wait_exec,
   input wire logic code_flash_pe_entry,
   input wire logic data_flash_pe_entry,
   input wire logic nmi_pin,
   input wire logic [15:0] external_pin_interrupt,
   input wire logic [7:0] periph_irq,
   input wire logic pod_event,
   input wire logic rtc_running,
   output lpm_mode_e mode_q,
   output logic [NMOD-1:0] mod_clk_en_q,
   output logic [NMOD-1:0] mod_pwr_q,
   output lpm_pin_s pins_q,
   output logic vdet_stop_q,
   output logic por_lowpwr_q,
   output logic [7:0] clk_gen_cfg_q,
   output logic pod_irq_q
);
   localparam logic [NMOD-1:0] ACS_OPT =
      NMOD'((1 << `LPM_MOD_TMR) | (1 << `LPM_MOD_POD));

   // ---------------------------------------------------------------
   // Reset release and pin synchronisers
   // ---------------------------------------------------------------
   logic rst_s1_q;
   logic rst_n;
   logic [16:0] pin_s1_q;
   logic [16:0] pin_s2_q;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_s1_q <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n <= rst_s1_q;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1_q <= 17'h00000;
         pin_s2_q <= 17'h00000;
      end else begin
         pin_s1_q <= {nmi_pin, external_pin_interrupt};
         pin_s2_q <= pin_s1_q;
      end
   end

   // ---------------------------------------------------------------
   // Register state
   // ---------------------------------------------------------------
   logic [7:0] prot_q;
   logic sbsel_q;
   logic bus_oe_q;
   logic acs_en_q;
   logic bclk_sel_q;
   logic [NMOD-1:0] mod_en_q;
   logic dpse_q;
   logic [1:0] dcut_q;
   logic m1ri_q;
   logic m2ri_q;
   logic pod_irq_en_q;

   logic acc;
   logic acc_wr;
   logic key_ok;
   logic wr_prot;
   logic wr_sby;
   logic wr_mstp;
   logic wr_dps;
   logic wr_lvd;
   logic wr_cgc;
   logic mapped;
   logic [31:0] rdata_d;

   function automatic logic is_map(logic [11:0] a);
      is_map = a == `LPM_OFF_PROT || a == `LPM_OFF_SBY ||
         a == `LPM_OFF_MSTP || a == `LPM_OFF_DPS ||
         a == `LPM_OFF_LVD || a == `LPM_OFF_CGC || a == `LPM_OFF_STAT;
   endfunction

   assign acc = psel & penable & pready;
   assign acc_wr = acc & pwrite;
   assign mapped = is_map(paddr);
   assign key_ok = pwdata[15:8] == `LPM_PROT_KEY && pstrb[1:0] == 2'b11;
   assign wr_prot = acc_wr && paddr == `LPM_OFF_PROT && key_ok;
   assign wr_sby = acc_wr && paddr == `LPM_OFF_SBY &&
      prot_q[`LPM_BIT_MODE_WE];
   assign wr_mstp = acc_wr && paddr == `LPM_OFF_MSTP &&
      prot_q[`LPM_BIT_MODE_WE];
   assign wr_dps = acc_wr && paddr == `LPM_OFF_DPS &&
      prot_q[`LPM_BIT_MODE_WE];
   assign wr_lvd = acc_wr && paddr == `LPM_OFF_LVD &&
      prot_q[`LPM_BIT_VMON_WE];
   assign wr_cgc = acc_wr && paddr == `LPM_OFF_CGC &&
      (prot_q[`LPM_BIT_CLK_WE] | prot_q[`LPM_BIT_MODE_WE]);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prot_q <= `LPM_RST_PROT;
      end else if (wr_prot) begin
         prot_q <= pwdata[7:0] & `LPM_PROT_MASK;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sbsel_q <= `LPM_RST_SBSEL;
         bus_oe_q <= `LPM_RST_BUS_OE;
      end else if (wr_sby) begin
         sbsel_q <= pwdata[`LPM_BIT_SBSEL];
         bus_oe_q <= pwdata[`LPM_BIT_BUS_OE];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         acs_en_q <= 1'b0;
         bclk_sel_q <= 1'b0;
         pod_irq_en_q <= 1'b0;
         mod_en_q <= '0;
      end else if (wr_mstp) begin
         acs_en_q <= pwdata[`LPM_BIT_ACS_EN];
         bclk_sel_q <= pwdata[`LPM_BIT_BCLK];
         pod_irq_en_q <= pwdata[`LPM_BIT_POD_IE];
         mod_en_q <= pwdata[NMOD-1:0];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dpse_q <= 1'b0;
         dcut_q <= 2'b00;
      end else if (wr_dps) begin
         dpse_q <= pwdata[`LPM_BIT_DPSE];
         dcut_q <= pwdata[1:0];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         m1ri_q <= 1'b0;
         m2ri_q <= 1'b0;
      end else if (wr_lvd) begin
         m1ri_q <= pwdata[`LPM_BIT_M1RI];
         m2ri_q <= pwdata[`LPM_BIT_M2RI];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         clk_gen_cfg_q <= `LPM_RST_CGC;
      end else if (wr_cgc) begin
         clk_gen_cfg_q <= pwdata[7:0];
      end
   end

   // ---------------------------------------------------------------
   // Bus answer: one wait state, data and error held with pready
   // ---------------------------------------------------------------
   logic pod_pend;

   always_comb begin
      rdata_d = 32'h00000000;
      case (paddr)
         `LPM_OFF_PROT: rdata_d[7:0] = prot_q;
         `LPM_OFF_SBY: begin
            rdata_d[`LPM_BIT_SBSEL] = sbsel_q;
            rdata_d[`LPM_BIT_BUS_OE] = bus_oe_q;
         end
         `LPM_OFF_MSTP: begin
            rdata_d[`LPM_BIT_ACS_EN] = acs_en_q;
            rdata_d[`LPM_BIT_BCLK] = bclk_sel_q;
            rdata_d[`LPM_BIT_POD_IE] = pod_irq_en_q;
            rdata_d[NMOD-1:0] = mod_en_q;
         end
         `LPM_OFF_DPS: begin
            rdata_d[`LPM_BIT_DPSE] = dpse_q;
            rdata_d[1:0] = dcut_q;
         end
         `LPM_OFF_LVD: rdata_d[1:0] = {m2ri_q, m1ri_q};
         `LPM_OFF_CGC: rdata_d[7:0] = clk_gen_cfg_q;
         `LPM_OFF_STAT: rdata_d[12:0] = {data_flash_pe_entry,
            code_flash_pe_entry, por_lowpwr_q, vdet_stop_q, pod_pend,
            3'b000, mode_q};
         default: rdata_d = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~mapped;
         if (psel && penable && !pready && !pwrite) begin
            prdata <= rdata_d;
         end
      end
   end

   // ---------------------------------------------------------------
   // Mode selection on wait and return on wake
   // ---------------------------------------------------------------
   logic flash_pe;
   logic wake_req;
   lpm_mode_e mode_d;
   lpm_wake_s wsrc;

   assign flash_pe = code_flash_pe_entry | data_flash_pe_entry;
   assign wsrc = '{nmi: pin_s2_q[16], irq: pin_s2_q[15:0],
      periph: periph_irq};

   function automatic lpm_mode_e entry_mode(logic sbsel, logic acs_en,
      logic fpe, logic dpse, logic ri);
      if (fpe) begin
         entry_mode = LPM_SLEEP;
      end else if (sbsel) begin
         entry_mode = (dpse && !ri) ? LPM_DSTBY : LPM_SSTBY;
      end else if (acs_en) begin
         entry_mode = LPM_ACS;
      end else begin
         entry_mode = LPM_SLEEP;
      end
   endfunction

   always_comb begin
      case (mode_q)
         LPM_RUN: mode_d = wait_exec ?
            entry_mode(sbsel_q, acs_en_q, flash_pe, dpse_q, m1ri_q | m2ri_q) :
            LPM_RUN;
         LPM_SLEEP, LPM_ACS, LPM_SSTBY, LPM_DSTBY:
            mode_d = wake_req ? LPM_RUN : mode_q;
         default: mode_d = LPM_RUN;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_q <= LPM_RUN;
      end else begin
         mode_q <= mode_d;
      end
   end

   lpm_wake u_wake (
      .clk(clk),
      .rst_n(rst_n),
      .src(wsrc),
      .mode(mode_q),
      .pod_event(pod_event),
      .pod_irq_en(pod_irq_en_q),
      .wake_req(wake_req),
      .pod_irq_q(pod_irq_q),
      .pod_pend_q(pod_pend)
   );

   // ---------------------------------------------------------------
   // Module clocks, power and pin states per mode
   // ---------------------------------------------------------------
   function automatic logic [NMOD-1:0] run_mask(lpm_mode_e m,
      logic [NMOD-1:0] en);
      case (m)
         LPM_RUN: run_mask = '1;
         LPM_SLEEP: run_mask = en;
         LPM_ACS: run_mask = en & ACS_OPT;
         default: run_mask = '0;
      endcase
   endfunction

   logic retained_d;
   logic stby_d;
   logic [NMOD-1:0] run_d;

   assign run_d = run_mask(mode_d, mod_en_q);
   assign retained_d = mode_d == LPM_ACS || mode_d == LPM_SSTBY ||
      mode_d == LPM_DSTBY;
   assign stby_d = mode_d == LPM_SSTBY || mode_d == LPM_DSTBY;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mod_clk_en_q <= '1;
         mod_pwr_q <= '1;
      end else begin
         mod_clk_en_q <= run_d;
         mod_pwr_q <= (mode_d == LPM_DSTBY) ? '0 : '1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pins_q <= '0;
      end else begin
         pins_q.bclk_keep <= retained_d & bclk_sel_q;
         pins_q.tmr_pins_keep <= retained_d & run_d[`LPM_MOD_TMR];
         pins_q.rtc_pins_keep <= retained_d & rtc_running;
         pins_q.bus_hold <= stby_d & bus_oe_q;
         pins_q.bus_hiz <= stby_d & ~bus_oe_q;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         vdet_stop_q <= 1'b0;
         por_lowpwr_q <= 1'b0;
      end else begin
         vdet_stop_q <= mode_d == LPM_DSTBY && dcut_q == `LPM_DCUT_FULL;
         por_lowpwr_q <= mode_d == LPM_DSTBY &&
            dcut_q == `LPM_DCUT_FULL;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   a_prot_key_only: assert property ($changed(prot_q) |->
      $past(acc_wr && paddr == `LPM_OFF_PROT && pwdata[15:8] == 8'ha5))
      else $error("protect register changed without key");
   a_prot_rsvd_zero: assert property (acc && !pwrite &&
      paddr == `LPM_OFF_PROT |-> prdata[31:4] == 28'h0 && !prdata[2])
      else $error("reserved protect bits read nonzero");
   a_sby_locked: assert property ($changed(sbsel_q) ||
      $changed(acs_en_q) |-> $past(prot_q[1]))
      else $error("power register written while locked");
   a_cgc_locked: assert property ($changed(clk_gen_cfg_q) |->
      $past(prot_q[0] || prot_q[1]))
      else $error("clock register written while locked");
   a_lvd_locked: assert property ($changed(m1ri_q) ||
      $changed(m2ri_q) |-> $past(prot_q[3]))
      else $error("monitor register written while locked");
   a_flash_sleep: assert property (mode_q == LPM_RUN &&
      wait_exec && flash_pe |=> mode_q == LPM_SLEEP)
      else $error("flash entry did not force sleep");
   a_deep_redirect: assert property (mode_q == LPM_RUN &&
      wait_exec && !flash_pe && sbsel_q && (m1ri_q || m2ri_q) |=>
      mode_q == LPM_SSTBY)
      else $error("deep standby not redirected");
   a_acs_entry: assert property (mode_q == LPM_RUN &&
      wait_exec && !flash_pe && !sbsel_q && acs_en_q |=>
      mode_q == LPM_ACS && !mod_clk_en_q[NMOD-1])
      else $error("clock stop entry wrong");
   a_retain_stop: assert property ($rose(mode_q == LPM_SSTBY) |->
      mod_clk_en_q == '0 && mod_pwr_q == '1)
      else $error("standby modules not retained");
   a_deep_power: assert property ($rose(mode_q == LPM_DSTBY) |->
      mod_pwr_q == '0 && por_lowpwr_q == (dcut_q == 2'b11))
      else $error("deep standby power or cut wrong");
   a_bus_pins: assert property (mode_q == LPM_SSTBY |->
      pins_q.bus_hiz == !bus_oe_q && pins_q.bus_hold == bus_oe_q)
      else $error("bus pin state wrong in standby");
   a_wake_exit: assert property (mode_q != LPM_RUN && wsrc.nmi |=>
      mode_q == LPM_RUN)
      else $error("nmi did not wake");

   c_acs_round: cover property (mode_q == LPM_ACS ##1 mode_q == LPM_RUN);
   c_deep_entry: cover property ($rose(mode_q == LPM_DSTBY));
   c_pod_late: cover property (pod_pend ##[1:20] pod_irq_q);
   c_prot_write: cover property (wr_prot ##[1:10] wr_sby);

endmodule // lpm_top

// *** dv/tb.sv ***
`timescale 1ns/1ps
`include "lpm_map.svh"
module tb
   import lpm_pkg::*;
;
   // ----------------------------------------------------------------
   // Clock, reset and stimulus signals
   // ----------------------------------------------------------------
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'h0;
   logic [31:0] prdata;
   logic pready, pslverr;
   logic wait_exec = 1'b0;
   logic code_flash_pe_entry = 1'b0, data_flash_pe_entry = 1'b0;
   logic nmi_pin = 1'b0;
   logic [15:0] external_pin_interrupt = 16'h0;
   logic [7:0] periph_irq = 8'h0;
   logic pod_event = 1'b0, rtc_running = 1'b0;
   lpm_mode_e mode_q;
   logic [2:0] mod_clk_en_q, mod_pwr_q;
   lpm_pin_s pins_q;
   logic vdet_stop_q, por_lowpwr_q, pod_irq_q;
   logic [7:0] clk_gen_cfg_q;
   logic [31:0] rd_q;
   logic err_q;
   int n_errors = 0, tests_run = 0, cyc = 0, n_pod = 0;

   always #20 clk = ~clk;

   lpm_top #(.NMOD(3)) DUT (.clk(clk), .arst_n(arst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .wait_exec(wait_exec), .code_flash_pe_entry(code_flash_pe_entry),
      .data_flash_pe_entry(data_flash_pe_entry), .nmi_pin(nmi_pin),
      .external_pin_interrupt(external_pin_interrupt),
      .periph_irq(periph_irq), .pod_event(pod_event),
      .rtc_running(rtc_running), .mode_q(mode_q),
      .mod_clk_en_q(mod_clk_en_q), .mod_pwr_q(mod_pwr_q), .pins_q(pins_q),
      .vdet_stop_q(vdet_stop_q), .por_lowpwr_q(por_lowpwr_q),
      .clk_gen_cfg_q(clk_gen_cfg_q), .pod_irq_q(pod_irq_q));

   // A hang counts as a mismatch and ends the run.
   always @(posedge clk) begin
      cyc++;
      if (pod_irq_q === 1'b1) n_pod++;
      if (cyc == 20000) begin
         n_errors++;
         test_done();
      end
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic test_done();
      $display("Checks %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // APB transfer; pready, read data and error are taken at one rising
   // edge, and the request is released only after that edge.
   task automatic apb(logic w, logic [11:0] a, logic [31:0] d,
                      logic [3:0] s);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd_q = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // A write returns at the falling edge, once the register has settled.
   task automatic wr(logic [11:0] a, logic [31:0] d);
      apb(1'b1, a, d, 4'hf);
      @(negedge clk);
   endtask

   task automatic prot(logic [7:0] v);
      apb(1'b1, `LPM_OFF_PROT, {16'h0, 8'ha5, v}, 4'h3);
   endtask

   task automatic rdchk(string nm, logic [11:0] a, logic [31:0] exp);
      apb(1'b0, a, 32'h0, 4'hf);
      chk(nm, exp, rd_q);
   endtask

   task automatic enter(lpm_mode_e m);
      @(posedge clk);
      wait_exec <= 1'b1;
      @(posedge clk);
      wait_exec <= 1'b0;
      @(negedge clk);
      chk("mode", 32'(m), 32'(mode_q));
   endtask

   // Holds a wake source until run is seen, within a bounded wait.
   task automatic wake(logic [24:0] v);
      int n;
      @(posedge clk);
      {nmi_pin, external_pin_interrupt, periph_irq} <= v;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (mode_q !== LPM_RUN && n < 10);
      chk("wake", 32'(LPM_RUN), 32'(mode_q));
      @(posedge clk);
      {nmi_pin, external_pin_interrupt, periph_irq} <= 25'h0;
      repeat (3) @(posedge clk);
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      rdchk("prot_rst", `LPM_OFF_PROT, 32'h0);
      rdchk("sby_rst", `LPM_OFF_SBY, 32'h4000);
      apb(1'b0, 12'h100, 32'h0, 4'hf);
      chk("slverr", 32'h1, 32'(err_q));
      wr(`LPM_OFF_CGC, 32'h3c);
      chk("cgc_locked", 32'h0, 32'(clk_gen_cfg_q));
      apb(1'b1, `LPM_OFF_PROT, 32'h5a0b, 4'h3);
      rdchk("prot_badkey", `LPM_OFF_PROT, 32'h0);
      apb(1'b1, `LPM_OFF_PROT, 32'ha50b, 4'h1);
      rdchk("prot_byte", `LPM_OFF_PROT, 32'h0);
      prot(8'hff);
      rdchk("prot_resv", `LPM_OFF_PROT, 32'h0b);
      prot(8'h01);
      wr(`LPM_OFF_CGC, 32'h3c);
      chk("cgc_b0", 32'h3c, 32'(clk_gen_cfg_q));
      wr(`LPM_OFF_SBY, 32'h8000);
      rdchk("sby_locked", `LPM_OFF_SBY, 32'h4000);
      wr(`LPM_OFF_LVD, 32'h3);
      rdchk("lvd_locked", `LPM_OFF_LVD, 32'h0);
      prot(8'h0a);
      wr(`LPM_OFF_CGC, 32'h5a);
      chk("cgc_b1", 32'h5a, 32'(clk_gen_cfg_q));
      wr(`LPM_OFF_LVD, 32'h1);
      rdchk("lvd_open", `LPM_OFF_LVD, 32'h1);
      wr(`LPM_OFF_LVD, 32'h0);
      // Sleep, then clock stop with the timer module kept running and a latched port event.
      wr(`LPM_OFF_MSTP, 32'h1);
      enter(LPM_SLEEP);
      chk("clk_sleep", 32'h1, 32'(mod_clk_en_q));
      wake(25'h1);
      wr(`LPM_OFF_MSTP, 32'h8001_0001);
      enter(LPM_ACS);
      chk("clk_acs", 32'h1, 32'(mod_clk_en_q));
      chk("tmr_pins", 32'h1, 32'(pins_q.tmr_pins_keep));
      @(posedge clk);
      pod_event <= 1'b1;
      @(posedge clk);
      pod_event <= 1'b0;
      repeat (4) @(negedge clk);
      chk("pod_stay", 32'(LPM_ACS), 32'(mode_q));
      chk("pod_none", 32'h0, 32'(n_pod));
      rdchk("stat_pend", `LPM_OFF_STAT, 32'h104);
      wake(25'h1 << 23);
      chk("pod_late", 32'h1, 32'(n_pod));
      // Flash entry overrides both clock stop and standby select.
      for (int i = 0; i < 4; i++) begin
         code_flash_pe_entry <= ~i[0];
         data_flash_pe_entry <= i[0];
         wr(`LPM_OFF_SBY, i[1] ? 32'hc000 : 32'h4000);
         enter(LPM_SLEEP);
         wake(25'h1 << i);
      end
      code_flash_pe_entry <= 1'b0;
      data_flash_pe_entry <= 1'b0;
      // Software standby with both bus pin choices.
      rtc_running <= 1'b1;
      wr(`LPM_OFF_SBY, 32'hc000);
      wr(`LPM_OFF_MSTP, 32'h4000_0000);
      enter(LPM_SSTBY);
      chk("clk_sby", 32'h0, 32'(mod_clk_en_q));
      chk("pwr_sby", 32'h7, 32'(mod_pwr_q));
      chk("hold", 32'h1, 32'(pins_q.bus_hold));
      chk("hiz0", 32'h0, 32'(pins_q.bus_hiz));
      chk("bclk", 32'h1, 32'(pins_q.bclk_keep));
      chk("rtc_pins", 32'h1, 32'(pins_q.rtc_pins_keep));
      wake(25'h1 << 24);
      wr(`LPM_OFF_SBY, 32'h8000);
      enter(LPM_SSTBY);
      chk("hiz1", 32'h1, 32'(pins_q.bus_hiz));
      chk("hold0", 32'h0, 32'(pins_q.bus_hold));
      wake(25'h1 << 7);
      // Deep standby, cut choices and the monitor override.
      wr(`LPM_OFF_DPS, 32'h83);
      enter(LPM_DSTBY);
      chk("pwr_deep", 32'h0, 32'(mod_pwr_q));
      chk("vdet", 32'h1, 32'(vdet_stop_q));
      chk("por", 32'h1, 32'(por_lowpwr_q));
      wake(25'h1 << 24);
      wr(`LPM_OFF_DPS, 32'h81);
      enter(LPM_DSTBY);
      chk("vdet_01", 32'h0, 32'(vdet_stop_q));
      wake(25'h1 << 8);
      wr(`LPM_OFF_LVD, 32'h2);
      enter(LPM_SSTBY);
      wake(25'h1 << 5);
      // Relock and confirm writes are dropped.
      prot(8'h00);
      wr(`LPM_OFF_SBY, 32'h0);
      rdchk("sby_relock", `LPM_OFF_SBY, 32'h8000);
      test_done();
   end
endmodule // tb
